// File: asa_pkg.sv
// Functional notes
// - Live bit shows alarm state at read
// - Sticky holds until host clears it
// - Sticky sets on rising and falling live
// - Alarm pin shows live or sticky, high=alarm
// - Per-pin polarity inversion option
// - Alert built from sticky bits only
// - Holdover live high while loop in holdover
// - Locked live needs loop and analog lock
// - Monitor gives offset, signal-loss, activity alarms
// - Loop entering state raises sticky; state readable
// - Each alarm: live, sticky, clear, output controls
// - Host clears one, some or all stickies
// - Block sticky also holds alert output
// - Alert negation may lag up to 200us
// - Global enable gates sticky setting of all alarm sources
// - Alert is OR of enabled sticky bits
// - Alert output polarity inversion option
// - Alert holds until all contributors cleared
// - Signal-loss pin follows live, never latched
package asa_pkg;
   localparam int NREF = 4;
   localparam int NLOOP = 5;
   localparam int SW = 3;
   localparam int NALM = 3 * NREF + 2 * NLOOP;
   localparam int NBLK = NREF + NLOOP;
   localparam int NPIN = 4;
   localparam int SYNC_W = 3 * NREF + SW * NLOOP + 1;
   localparam int CNT_W = 12;

   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_LIVE = 8'h04;
   localparam logic [7:0] OFF_STICKY = 8'h08;
   localparam logic [7:0] OFF_BLK = 8'h0c;
   localparam logic [7:0] OFF_ALERT_EN = 8'h10;
   localparam logic [7:0] OFF_PIN_CFG = 8'h14;
   localparam logic [7:0] OFF_LOOP_ST = 8'h18;

   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_INV_BIT = 1;
   localparam int PIN_IDX_LSB = 0;
   localparam int PIN_STK_BIT = 5;
   localparam int PIN_INV_BIT = 6;
   localparam int PIN_EN_BIT = 7;
   localparam int PIN_CFG_W = 8;

   localparam int ALM_FREQ = 0;
   localparam int ALM_LOS = 1;
   localparam int ALM_ACT = 2;
   localparam int ALM_LOOP_BASE = 3 * NREF;
   localparam int ALM_HOLD = 0;
   localparam int ALM_LOCK = 1;

   localparam logic [SW-1:0] LOOP_ST_LOCKED = 3'h3;
   localparam logic [SW-1:0] LOOP_ST_HOLDOVER = 3'h4;

   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [NALM-1:0] ALERT_EN_RST = 22'h0;
   localparam logic [31:0] PIN_CFG_RST = 32'h0;

   localparam int CLK_MHZ = 20;
   localparam int ALERT_NEG_US = 200;
   localparam int ALERT_NEG_CYC = ALERT_NEG_US * CLK_MHZ;
   localparam logic [CNT_W-1:0] NEG_LAST = CNT_W'(ALERT_NEG_CYC - 1);

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } asa_ahb_req_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } asa_ahb_rsp_t;

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
   } asa_sync_t;

   typedef struct packed {
      logic [1:0] ctrl;
      logic [NALM-1:0] alert_en;
      logic [31:0] pin_cfg;
      logic [NALM-1:0] sticky;
      logic [NBLK-1:0] blk;
      logic [NALM-1:0] live_prev;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic [CNT_W-1:0] neg_cnt;
      logic alert;
      logic alert_out;
      logic [NPIN-1:0] pins;
   } asa_state_t;

   localparam asa_state_t ST_RST = '{ctrl: CTRL_RST, alert_en: ALERT_EN_RST, pin_cfg: PIN_CFG_RST, default: '0};
endpackage : asa_pkg

// File: asa_sync.sv
`timescale 1ns/1ps
module asa_sync (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [asa_pkg::SYNC_W-1:0] d,
   output logic [asa_pkg::SYNC_W-1:0] q
);
   import asa_pkg::*;

   asa_sync_t st_q;
   asa_sync_t st_d;

   // Second stage alone reads the first one
   always_comb begin
      st_d = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule : asa_sync

// File: asa_alarm_agg.sv
`timescale 1ns/1ps
module asa_alarm_agg (
   input wire logic hclk,
   input wire logic hresetn,
   input wire asa_pkg::asa_ahb_req_t ahb_req,
   output asa_pkg::asa_ahb_rsp_t ahb_rsp,
   input wire logic [3*asa_pkg::NREF-1:0] ref_alarm,
   input wire logic [asa_pkg::SW*asa_pkg::NLOOP-1:0] loop_state,
   input wire logic apll_locked,
   output logic [asa_pkg::NPIN-1:0] alarm_pin,
   output logic alert_pin
);
   import asa_pkg::*;

   asa_state_t st_q;
   asa_state_t st_d;
   logic [SYNC_W-1:0] sync_q;
   logic [NALM-1:0] live;
   logic [NALM-1:0] chg;
   logic [NALM-1:0] set_v;
   logic [NALM-1:0] clr_v;
   logic [NBLK-1:0] blk_set;
   logic [NBLK-1:0] blk_clr;
   logic [NBLK-1:0] blk_en;
   logic addr_ok;
   logic alert_src;

   function automatic logic [NALM-1:0] blk_mask(input int b);
      logic [NALM-1:0] m;
      m = '0;
      if (b < NREF) begin
         m[3*b +: 3] = 3'h7;
      end else begin
         m[ALM_LOOP_BASE + 2*(b-NREF) +: 2] = 2'h3;
      end
      return m;
   endfunction : blk_mask

   function automatic logic [SW-1:0] loop_st(input logic [SYNC_W-1:0] v, input int l);
      return v[3*NREF + SW*l +: SW];
   endfunction : loop_st

   function automatic logic is_los(input logic [4:0] i);
      return (i < 5'(3*NREF)) && ((i % 5'd3) == 5'(ALM_LOS));
   endfunction : is_los

   function automatic logic pin_val(
      input logic [PIN_CFG_W-1:0] c,
      input logic [NALM-1:0] lv,
      input logic [NALM-1:0] stk
   );
      logic [4:0] i;
      logic b;
      i = c[PIN_IDX_LSB +: 5];
      b = 1'b0;
      if (i < 5'(NALM)) begin
         // Signal-loss alarms never use the sticky copy on a pin
         if (c[PIN_STK_BIT] && !is_los(i)) begin
            b = stk[i];
         end else begin
            b = lv[i];
         end
      end
      return c[PIN_EN_BIT] & (b ^ c[PIN_INV_BIT]);
   endfunction : pin_val

   asa_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({apll_locked, loop_state, ref_alarm}),
      .q(sync_q)
   );

   always_comb begin
      live = '0;
      live[3*NREF-1:0] = sync_q[3*NREF-1:0];
      for (int l = 0; l < NLOOP; l++) begin
         live[ALM_LOOP_BASE + 2*l + ALM_HOLD] = (loop_st(sync_q, l) == LOOP_ST_HOLDOVER);
         live[ALM_LOOP_BASE + 2*l + ALM_LOCK] = (loop_st(sync_q, l) == LOOP_ST_LOCKED)
            && sync_q[SYNC_W-1];
      end
   end

   always_comb begin
      st_d = st_q;
      addr_ok = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
      chg = live ^ st_q.live_prev;
      // Both edges count, so a loop entering a state is seen too
      set_v = st_q.ctrl[CTRL_EN_BIT] ? chg : '0;
      clr_v = '0;
      blk_clr = '0;
      blk_set = '0;
      blk_en = '0;

      // Write data phase; registers are word wide, hsize not checked
      if (st_q.wr_pend) begin
         if (st_q.wr_addr == OFF_CTRL) begin
            st_d.ctrl = ahb_req.hwdata[1:0];
         end else if (st_q.wr_addr == OFF_STICKY) begin
            clr_v = ahb_req.hwdata[NALM-1:0];
         end else if (st_q.wr_addr == OFF_BLK) begin
            blk_clr = ahb_req.hwdata[NBLK-1:0];
         end else if (st_q.wr_addr == OFF_ALERT_EN) begin
            st_d.alert_en = ahb_req.hwdata[NALM-1:0];
         end else if (st_q.wr_addr == OFF_PIN_CFG) begin
            st_d.pin_cfg = ahb_req.hwdata;
         end
      end

      // A fresh change beats a clear landing in the same cycle
      st_d.sticky = (st_q.sticky & ~clr_v) | set_v;
      st_d.live_prev = live;

      // Block bit re-arms while any of its stickies is still up
      for (int b = 0; b < NBLK; b++) begin
         blk_set[b] = |(st_d.sticky & blk_mask(b));
         blk_en[b] = |(st_q.alert_en & blk_mask(b));
      end
      st_d.blk = (st_q.blk & ~blk_clr) | blk_set;

      alert_src = (|(st_q.sticky & st_q.alert_en)) || (|(st_q.blk & blk_en));

      // Slow release keeps a level-sensitive host from seeing bursts
      if (alert_src) begin
         st_d.alert = 1'b1;
         st_d.neg_cnt = '0;
      end else if (st_q.alert) begin
         if (st_q.neg_cnt == NEG_LAST) begin
            st_d.alert = 1'b0;
            st_d.neg_cnt = '0;
         end else begin
            st_d.neg_cnt = st_q.neg_cnt + CNT_W'(1);
         end
      end
      st_d.alert_out = st_d.alert ^ st_q.ctrl[CTRL_INV_BIT];

      for (int p = 0; p < NPIN; p++) begin
         st_d.pins[p] = pin_val(st_q.pin_cfg[PIN_CFG_W*p +: PIN_CFG_W], live, st_q.sticky);
      end

      st_d.wr_pend = addr_ok && ahb_req.hwrite;
      st_d.wr_addr = ahb_req.haddr[7:0];

      // Read data is captured at the address phase edge
      if (addr_ok && !ahb_req.hwrite) begin
         if (ahb_req.haddr[7:0] == OFF_CTRL) begin
            st_d.rdata = {30'h0, st_q.ctrl};
         end else if (ahb_req.haddr[7:0] == OFF_LIVE) begin
            st_d.rdata = {10'h0, live};
         end else if (ahb_req.haddr[7:0] == OFF_STICKY) begin
            st_d.rdata = {10'h0, st_q.sticky};
         end else if (ahb_req.haddr[7:0] == OFF_BLK) begin
            st_d.rdata = {23'h0, st_q.blk};
         end else if (ahb_req.haddr[7:0] == OFF_ALERT_EN) begin
            st_d.rdata = {10'h0, st_q.alert_en};
         end else if (ahb_req.haddr[7:0] == OFF_PIN_CFG) begin
            st_d.rdata = st_q.pin_cfg;
         end else if (ahb_req.haddr[7:0] == OFF_LOOP_ST) begin
            st_d.rdata = {17'h0, sync_q[3*NREF +: SW*NLOOP]};
         end else begin
            st_d.rdata = 32'h0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign ahb_rsp.hrdata = st_q.rdata;
   assign ahb_rsp.hreadyout = 1'b1;
   assign ahb_rsp.hresp = 1'b0;
   assign alarm_pin = st_q.pins;
   assign alert_pin = st_q.alert_out;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_rd(logic [7:0] a);
      addr_ok && !ahb_req.hwrite && (ahb_req.haddr[7:0] == a);
   endsequence

   sequence s_wr(logic [7:0] a);
      addr_ok && ahb_req.hwrite && (ahb_req.haddr[7:0] == a);
   endsequence

   sequence s_src_gone;
      st_q.alert && !alert_src;
   endsequence

   // Address phase taken, then its data phase
   sequence s_wr_data(logic [7:0] a);
      s_wr(a) ##1 1'b1;
   endsequence

   a_live_read: assert property (s_rd(OFF_LIVE) |=> ahb_rsp.hrdata == {10'h0, $past(live)})
      else $error("live read does not match live state");

   a_sticky_hold: assert property ((clr_v == '0) |=> (($past(st_q.sticky) & ~st_q.sticky) == '0))
      else $error("sticky bit dropped without a clear");

   a_sticky_edge: assert property ((st_q.ctrl[CTRL_EN_BIT] && (chg != '0))
      |=> ((st_q.sticky & $past(chg)) == $past(chg)))
      else $error("live change did not set sticky");

   a_set_wins: assert property ((set_v != '0) && (clr_v != '0)
      |=> ((st_q.sticky & $past(set_v)) == $past(set_v)))
      else $error("clear overrode a same-cycle event");

   a_w1c_clear: assert property (s_wr(OFF_STICKY) ##1 ((set_v == '0) && (clr_v != '0))
      |=> ((st_q.sticky & $past(clr_v)) == '0))
      else $error("sticky clear had no effect");

   a_gate_off: assert property ((!st_q.ctrl[CTRL_EN_BIT] && (clr_v == '0))
      |=> (st_q.sticky == $past(st_q.sticky)))
      else $error("sticky set while alarms disabled");

   a_hold_live: assert property (live[ALM_LOOP_BASE + 2*(NLOOP-1) + ALM_HOLD]
      == ($past(loop_state[SW*(NLOOP-1) +: SW], 2) == LOOP_ST_HOLDOVER))
      else $error("system loop holdover live wrong");

   a_lock_live: assert property (live[ALM_LOOP_BASE + ALM_LOCK]
      == (($past(loop_state[0 +: SW], 2) == LOOP_ST_LOCKED) && $past(apll_locked, 2)))
      else $error("loop locked live wrong");

   a_ref_live: assert property (live[3*NREF-1:0] == $past(ref_alarm, 2))
      else $error("monitor live bits not two cycles behind inputs");

   a_blk_set: assert property ((|(st_q.sticky & blk_mask(0))) |=> st_q.blk[0])
      else $error("block sticky not set by member");

   a_alert_src: assert property ((|(st_q.sticky & st_q.alert_en)) |=> st_q.alert)
      else $error("enabled sticky did not raise alert");

   a_alert_hold: assert property (st_q.alert && alert_src |=> st_q.alert ##1 st_q.alert)
      else $error("alert dropped with contributors pending");

   a_alert_neg: assert property ($fell(st_q.alert) |-> $past(st_q.neg_cnt) == NEG_LAST)
      else $error("alert released at wrong count");

   a_neg_count: assert property (s_src_gone ##1 s_src_gone |-> st_q.neg_cnt != '0)
      else $error("release counter not running");

   a_alert_inv: assert property (alert_pin == (st_q.alert ^ $past(st_q.ctrl[CTRL_INV_BIT])))
      else $error("alert polarity wrong");

   a_los_pin: assert property ((st_q.pin_cfg[PIN_EN_BIT] && is_los(st_q.pin_cfg[PIN_IDX_LSB +: 5]))
      |=> alarm_pin[0] == ($past(live[st_q.pin_cfg[PIN_IDX_LSB +: 5]]) ^ $past(st_q.pin_cfg[PIN_INV_BIT])))
      else $error("signal-loss pin not following live");

   a_pin_off: assert property (!st_q.pin_cfg[PIN_EN_BIT] |=> !alarm_pin[0])
      else $error("disabled alarm pin driven high");

   a_pin3_off: assert property (!st_q.pin_cfg[3*PIN_CFG_W + PIN_EN_BIT]
      |=> !alarm_pin[3])
      else $error("disabled last pin driven high");

   a_pin_live: assert property (st_q.pin_cfg[PIN_EN_BIT] && !st_q.pin_cfg[PIN_STK_BIT]
      && (st_q.pin_cfg[PIN_IDX_LSB +: 5] < 5'(NALM))
      |=> alarm_pin[0] == ($past(live[st_q.pin_cfg[PIN_IDX_LSB +: 5]]) ^ $past(st_q.pin_cfg[PIN_INV_BIT])))
      else $error("live-mode pin wrong");

   a_pin_sticky: assert property (st_q.pin_cfg[PIN_CFG_W + PIN_EN_BIT] && st_q.pin_cfg[PIN_CFG_W + PIN_STK_BIT]
      && !is_los(st_q.pin_cfg[PIN_CFG_W + PIN_IDX_LSB +: 5])
      && (st_q.pin_cfg[PIN_CFG_W + PIN_IDX_LSB +: 5] < 5'(NALM))
      |=> alarm_pin[1] == ($past(st_q.sticky[st_q.pin_cfg[PIN_CFG_W + PIN_IDX_LSB +: 5]])
         ^ $past(st_q.pin_cfg[PIN_CFG_W + PIN_INV_BIT])))
      else $error("sticky-mode pin wrong");

   a_ctrl_write: assert property (s_wr_data(OFF_CTRL)
      |=> st_q.ctrl == $past(ahb_req.hwdata[1:0]))
      else $error("control write did not land");

   a_en_write: assert property (s_wr_data(OFF_ALERT_EN)
      |=> st_q.alert_en == $past(ahb_req.hwdata[NALM-1:0]))
      else $error("alert enable write did not land");

   a_cfg_write: assert property (s_wr_data(OFF_PIN_CFG)
      |=> st_q.pin_cfg == $past(ahb_req.hwdata))
      else $error("pin config write did not land");

   a_ctrl_read: assert property (s_rd(OFF_CTRL)
      |=> ahb_rsp.hrdata == {30'h0, $past(st_q.ctrl)})
      else $error("control read wrong");

   a_sticky_read: assert property (s_rd(OFF_STICKY)
      |=> ahb_rsp.hrdata == {10'h0, $past(st_q.sticky)})
      else $error("sticky read wrong");

   a_blk_read: assert property (s_rd(OFF_BLK)
      |=> ahb_rsp.hrdata == {23'h0, $past(st_q.blk)})
      else $error("block sticky read wrong");

   a_state_read: assert property (s_rd(OFF_LOOP_ST)
      |=> ahb_rsp.hrdata == {17'h0, $past(sync_q[3*NREF +: SW*NLOOP])})
      else $error("loop state read wrong");

   a_blk_clear: assert property (s_wr(OFF_BLK) ##1 (blk_set == '0)
      |=> ((st_q.blk & $past(blk_clr)) == '0))
      else $error("block clear had no effect");

   a_blk_hold: assert property ((blk_clr == '0)
      |=> (($past(st_q.blk) & ~st_q.blk) == '0))
      else $error("block sticky dropped without a clear");

   a_sys_lock: assert property (live[ALM_LOOP_BASE + 2*(NLOOP-1) + ALM_LOCK]
      == (($past(loop_state[SW*(NLOOP-1) +: SW], 2) == LOOP_ST_LOCKED) && $past(apll_locked, 2)))
      else $error("system loop locked live wrong");

   a_hold0_live: assert property (live[ALM_LOOP_BASE + ALM_HOLD]
      == ($past(loop_state[0 +: SW], 2) == LOOP_ST_HOLDOVER))
      else $error("loop holdover live wrong");

   a_lock_apll: assert property (!sync_q[SYNC_W-1]
      |-> !live[ALM_LOOP_BASE + ALM_LOCK])
      else $error("locked live high without analog lock");

   a_alert_quiet: assert property (!st_q.alert && !alert_src
      |=> !st_q.alert)
      else $error("alert raised with no sticky source");

   a_blk_alert: assert property ((|(st_q.blk & blk_en))
      |=> st_q.alert)
      else $error("block sticky did not hold alert");

   a_neg_restart: assert property (alert_src
      |=> st_q.neg_cnt == '0)
      else $error("release counter ran with a source pending");
endmodule : asa_alarm_agg

// File: asa_host.sv
`timescale 1ns/1ps
module asa_host (
   input wire logic hclk,
   output asa_pkg::asa_ahb_req_t req,
   input wire asa_pkg::asa_ahb_rsp_t rsp
);
   import asa_pkg::*;
   // Host polls registers only; it never uses the alert pin as an edge interrupt
   asa_ahb_req_t r = '0;
   always_comb begin
      req = r;
      req.hready = rsp.hreadyout;
   end
   // Callers enter right after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      r.hsel <= 1'b1;
      r.haddr <= {24'h0, a};
      r.htrans <= 2'h2;
      r.hwrite <= 1'b1;
      r.hsize <= 3'h2;
      do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
      r.hsel <= 1'b0;
      r.htrans <= 2'h0;
      r.hwdata <= d;
      do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      r.hsel <= 1'b1;
      r.haddr <= {24'h0, a};
      r.htrans <= 2'h2;
      r.hwrite <= 1'b0;
      r.hsize <= 3'h2;
      do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
      r.hsel <= 1'b0;
      r.htrans <= 2'h0;
      do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
      d = rsp.hrdata;
   endtask : rd
endmodule : asa_host

// File: tb.sv
`timescale 1ns/1ps
module tb;
   import asa_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   asa_ahb_req_t req;
   asa_ahb_rsp_t rsp;
   logic [3*NREF-1:0] ref_in = '0;
   logic [SW*NLOOP-1:0] loop_st = '0;
   logic apll = 1'b0;
   logic [NPIN-1:0] pins;
   logic alert;
   int fails = 0;
   int cmp_count = 0;
   always #25 hclk = ~hclk;
   asa_host host (.hclk(hclk), .req(req), .rsp(rsp));
   asa_alarm_agg dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp),
      .ref_alarm(ref_in), .loop_state(loop_st), .apll_locked(apll),
      .alarm_pin(pins), .alert_pin(alert));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Pin levels as {alert, alarm pins}
   task automatic pchk(input logic [4:0] e);
      cmp_count++;
      if ({alert, pins} !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {alert, pins}, e);
      end
   endtask : pchk
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      host.rd(a, v);
      chk(v, e);
   endtask : rchk
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   // Whole run is about 4200 cycles
   initial begin
      cyc(20000);
      fails++;
      finish_test();
   end
   initial begin
      cyc(10);
      hresetn <= 1'b1;
      cyc(2);
      pchk(5'h00);
      rchk(OFF_CTRL, 32'h0);
      rchk(OFF_ALERT_EN, 32'h0);
      rchk(OFF_PIN_CFG, 32'h0);
      host.wr(8'h1c, 32'hffffffff);
      rchk(8'h1c, 32'h0);
      // Enable off: live follows, no sticky
      ref_in <= 12'h001;
      cyc(4);
      rchk(OFF_LIVE, 32'h1);
      rchk(OFF_STICKY, 32'h0);
      ref_in <= 12'h000;
      cyc(4);
      host.wr(OFF_CTRL, 32'h1);
      ref_in <= 12'h002;
      cyc(4);
      rchk(OFF_LIVE, 32'h2);
      rchk(OFF_STICKY, 32'h2);
      rchk(OFF_BLK, 32'h1);
      host.wr(OFF_STICKY, 32'h2);
      rchk(OFF_STICKY, 32'h0);
      ref_in <= 12'h000;
      cyc(4);
      rchk(OFF_STICKY, 32'h2);
      rchk(OFF_LIVE, 32'h0);
      // Loop 0: holdover, then locked with and without analog lock
      loop_st <= 15'h4;
      apll <= 1'b1;
      cyc(4);
      rchk(OFF_LIVE, 32'h1000);
      rchk(OFF_LOOP_ST, 32'h4);
      rchk(OFF_STICKY, 32'h1002);
      loop_st <= 15'h3;
      cyc(4);
      rchk(OFF_LIVE, 32'h2000);
      rchk(OFF_STICKY, 32'h3002);
      apll <= 1'b0;
      cyc(4);
      rchk(OFF_LIVE, 32'h0);
      host.wr(OFF_STICKY, 32'h1000);
      rchk(OFF_STICKY, 32'h2002);
      // Individual bits first so the block bits stay clear
      host.wr(OFF_STICKY, 32'h3fffff);
      host.wr(OFF_BLK, 32'h1ff);
      rchk(OFF_STICKY, 32'h0);
      rchk(OFF_BLK, 32'h0);
      // Pin0 loss idx1 (sticky mode ignored), pin1 holdover sticky, pin2 idx0 inverted
      host.wr(OFF_PIN_CFG, 32'h00c0aca1);
      cyc(2);
      pchk(5'h04);
      ref_in <= 12'h003;
      loop_st <= 15'h4;
      cyc(5);
      pchk(5'h03);
      ref_in <= 12'h000;
      cyc(5);
      pchk(5'h06);
      // Alert from sticky of idx0 while its live bit is low
      host.wr(OFF_ALERT_EN, 32'h1);
      cyc(3);
      pchk(5'h16);
      host.wr(OFF_CTRL, 32'h3);
      cyc(2);
      pchk(5'h06);
      host.wr(OFF_CTRL, 32'h1);
      host.wr(OFF_STICKY, 32'h3fffff);
      cyc(3);
      pchk(5'h14);
      host.wr(OFF_BLK, 32'h1ff);
      cyc(3900);
      pchk(5'h14);
      cyc(200);
      pchk(5'h04);
      finish_test();
   end
endmodule : tb
